// file: hdl/wake_pkg.sv
// Shared constants and types for the break wake-up serial slave.
// Assumes one 200 MHz clock and 8N1 character framing.
package wake_pkg;

  // ****************************************************************
  // Character and break framing
  // ****************************************************************
  localparam int unsigned CLK_MHZ = 200;
  localparam logic [3:0] CHAR_BITS = 4'ha;
  localparam logic [3:0] DATA_BITS = 4'h8;
  localparam logic [1:0] BREAK_CHARS = 2'h3;
  localparam logic [5:0] BREAK_BITS = 6'(CHAR_BITS) * 6'(BREAK_CHARS);
  // Break is the line's asserted state, low at the logic pin
  localparam logic BREAK_LVL = 1'b0;
  localparam logic IDLE_LVL = 1'b1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [1:0] SYNC_RST = 2'h3;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [5:0] BRK_RST = 6'h00;
  localparam logic [9:0] TX_SHIFT_RST = 10'h3ff;

  typedef enum logic [1:0] {
    ST_SLEEP,
    ST_LISTEN,
    ST_ATTACHED
  } wake_state_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_BITS,
    RX_WAIT_IDLE
  } rx_state_t;

endpackage

// file: hdl/char_rx.sv
// Serial character receiver, 8N1, mid-bit sampling.
// Assumes a synchronised line input and a divisor of at least 2.
`timescale 1ns/10ps
module char_rx
  import wake_pkg::*;
(
  // Clocking
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Line and timing
  input wire logic rxd,
  input wire logic [15:0] baud_div,
  // Received character
  output logic [7:0] data_q,
  output logic valid_q,
  output logic ferr_q
);

  rx_state_t state_q;
  logic [15:0] cnt_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;

  // ****************************************************************
  // Framing
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= RX_WAIT_IDLE;
      cnt_q <= DIV_RST;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      data_q <= 8'h00;
      valid_q <= 1'b0;
      ferr_q <= 1'b0;
    end else if (ce) begin
      valid_q <= 1'b0;
      ferr_q <= 1'b0;
      case (state_q)
        RX_IDLE: begin
          if (rxd == BREAK_LVL) begin
            state_q <= RX_BITS;
            cnt_q <= {1'b0, baud_div[15:1]};
            bit_q <= 4'h0;
          end
        end
        RX_BITS: begin
          if (cnt_q != 16'h0000) begin
            cnt_q <= cnt_q - 16'h0001;
          end else begin
            cnt_q <= baud_div - 16'h0001;
            bit_q <= bit_q + 4'h1;
            if (bit_q == 4'h0 && rxd != BREAK_LVL) begin
              state_q <= RX_IDLE;
            end else if (bit_q == CHAR_BITS - 4'h1) begin
              // Bad stop bit: a break lands here and is dropped
              if (rxd == IDLE_LVL) begin
                data_q <= shift_q;
                valid_q <= 1'b1;
                state_q <= RX_IDLE;
              end else begin
                ferr_q <= 1'b1;
                state_q <= RX_WAIT_IDLE;
              end
            end else if (bit_q != 4'h0) begin
              shift_q <= {rxd, shift_q[7:1]};
            end
          end
        end
        default: begin
          if (rxd == IDLE_LVL) begin
            state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

endmodule

// file: hdl/break_wake.sv
// Serial slave front end with break wake-up and cable detection.
// Assumes message checking logic on mclk answers msg_ok or msg_bad.
`timescale 1ns/10ps
module break_wake
  import wake_pkg::*;
(
  // Clocking
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Serial pins
  input wire logic rxd,
  input wire logic cts,
  output logic txd_q,
  // Configuration
  input wire logic break_free,
  input wire logic [15:0] baud_div,
  // Received characters and message verdict
  output logic [7:0] rx_data_q,
  output logic rx_valid_q,
  output logic frame_err_q,
  input wire logic msg_ok,
  input wire logic msg_bad,
  input wire logic detach,
  // Reply transmit
  input wire logic tx_start,
  input wire logic [7:0] tx_data,
  output logic tx_busy_q,
  // Status
  output logic break_det_q,
  output logic awake_q,
  output logic attached_q,
  output logic cable_q
);

  wake_state_t state_q;
  logic [1:0] rxd_sq;
  logic [1:0] cts_sq;
  logic [1:0] bf_sq;
  logic line;
  logic bf;
  logic [15:0] brk_cnt_q;
  logic [5:0] brk_bits_q;
  logic brk_tick;
  logic brk_hit;
  logic [7:0] fr_data;
  logic fr_valid;
  logic fr_ferr;
  logic [9:0] tx_shift_q;
  logic [15:0] tx_cnt_q;
  logic [3:0] tx_bits_q;
  logic tx_go;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      rxd_sq <= SYNC_RST;
      cts_sq <= 2'h0;
      bf_sq <= 2'h0;
    end else if (ce) begin
      rxd_sq <= {rxd_sq[0], rxd};
      cts_sq <= {cts_sq[0], cts};
      bf_sq <= {bf_sq[0], break_free};
    end
  end

  assign line = rxd_sq[1];
  assign bf = bf_sq[1];

  // ****************************************************************
  // Break detection
  // ****************************************************************
  assign brk_tick = (brk_cnt_q == baud_div - 16'h0001);
  assign brk_hit = brk_tick && line == BREAK_LVL
                   && brk_bits_q == BREAK_BITS - 6'h01;

  // Count whole bit times at break level, restart on idle
  always_ff @(posedge mclk) begin
    if (rst) begin
      brk_cnt_q <= DIV_RST;
      brk_bits_q <= BRK_RST;
    end else if (ce) begin
      if (line != BREAK_LVL) begin
        brk_cnt_q <= DIV_RST;
        brk_bits_q <= BRK_RST;
      end else if (brk_tick) begin
        brk_cnt_q <= DIV_RST;
        if (brk_bits_q != BREAK_BITS) begin
          brk_bits_q <= brk_bits_q + 6'h01;
        end
      end else begin
        brk_cnt_q <= brk_cnt_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      break_det_q <= 1'b0;
    end else if (ce) begin
      break_det_q <= brk_hit;
    end
  end

  // ****************************************************************
  // Character receiver
  // ****************************************************************
  char_rx u_rx (
    .mclk(mclk),
    .rst(rst),
    .ce(ce),
    .rxd(line),
    .baud_div(baud_div),
    .data_q(fr_data),
    .valid_q(fr_valid),
    .ferr_q(fr_ferr)
  );

  // Characters reach the checker only while awake
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      frame_err_q <= 1'b0;
    end else if (ce) begin
      rx_valid_q <= fr_valid && state_q != ST_SLEEP;
      frame_err_q <= fr_ferr && state_q != ST_SLEEP;
      if (fr_valid) begin
        rx_data_q <= fr_data;
      end
    end
  end

  // ****************************************************************
  // Wake state machine
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_q <= ST_SLEEP;
    end else if (ce) begin
      case (state_q)
        ST_SLEEP: begin
          if (brk_hit || bf) begin
            state_q <= ST_LISTEN;
          end
        end
        ST_LISTEN: begin
          if (msg_ok) begin
            state_q <= ST_ATTACHED;
          end else if (msg_bad) begin
            state_q <= ST_SLEEP;
          end
        end
        default: begin
          if (brk_hit) begin
            state_q <= ST_LISTEN;
          end else if (detach) begin
            state_q <= ST_SLEEP;
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      awake_q <= 1'b0;
      attached_q <= 1'b0;
      cable_q <= 1'b0;
    end else if (ce) begin
      awake_q <= state_q != ST_SLEEP;
      attached_q <= state_q == ST_ATTACHED;
      cable_q <= cts_sq[1];
    end
  end

  // ****************************************************************
  // Reply transmitter
  // ****************************************************************
  // Replies only once attached; CTS plays no part
  assign tx_go = tx_start && !tx_busy_q && state_q == ST_ATTACHED;

  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_shift_q <= TX_SHIFT_RST;
      tx_cnt_q <= DIV_RST;
      tx_bits_q <= 4'h0;
      tx_busy_q <= 1'b0;
      txd_q <= IDLE_LVL;
    end else if (ce) begin
      if (tx_go) begin
        tx_shift_q <= {IDLE_LVL, tx_data, BREAK_LVL};
        tx_cnt_q <= DIV_RST;
        tx_bits_q <= 4'h0;
        tx_busy_q <= 1'b1;
        txd_q <= BREAK_LVL;
      end else if (tx_busy_q) begin
        if (tx_cnt_q == baud_div - 16'h0001) begin
          tx_cnt_q <= DIV_RST;
          if (tx_bits_q == CHAR_BITS - 4'h1) begin
            tx_busy_q <= 1'b0;
            txd_q <= IDLE_LVL;
          end else begin
            tx_bits_q <= tx_bits_q + 4'h1;
            tx_shift_q <= {IDLE_LVL, tx_shift_q[9:1]};
            txd_q <= tx_shift_q[1];
          end
        end else begin
          tx_cnt_q <= tx_cnt_q + 16'h0001;
        end
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence tx_begin_s;
    ce && tx_start && !tx_busy_q && state_q == ST_ATTACHED;
  endsequence

  sequence tx_start_bit_s;
    tx_busy_q && txd_q == BREAK_LVL;
  endsequence

  sleep_drop_a: assert property (
    ce && state_q == ST_SLEEP && fr_valid |=> !rx_valid_q)
    else $error("character passed while sleeping");

  break_wakes_a: assert property (
    ce && state_q == ST_SLEEP && brk_hit |=> state_q == ST_LISTEN)
    else $error("break did not wake slave");

  break_count_a: assert property (
    ce && brk_tick && line == BREAK_LVL
    && brk_bits_q == BREAK_BITS - 6'h01 |=> break_det_q)
    else $error("break not flagged at threshold");

  break_early_a: assert property (
    break_det_q |-> $past(brk_bits_q) == BREAK_BITS - 6'h01)
    else $error("break flagged before threshold");

  reply_gate_a: assert property (
    $rose(tx_busy_q) |-> $past(state_q) == ST_ATTACHED)
    else $error("reply before message accepted");

  tx_no_cts_a: assert property (
    tx_begin_s |=> tx_start_bit_s)
    else $error("transmit held back");

  break_free_a: assert property (
    ce && bf && state_q == ST_SLEEP |=> state_q == ST_LISTEN)
    else $error("break-free slave stays asleep");

  cable_follow_a: assert property (
    ce ##1 ce |-> cable_q == $past(cts_sq[1]))
    else $error("cable flag not tracking cts");

endmodule

// file: bench/serial_master.sv
// Remote serial master model driving the slave's receive pin.
// Assumes the bench calls its tasks; one bit time is div clock cycles.
`timescale 1ns/10ps
module serial_master
  import wake_pkg::*;
(
  // Clocking
  input wire logic mclk,
  // Line
  output logic rxd,
  input wire logic [15:0] div
);
  initial rxd = IDLE_LVL;

  task automatic hold(input logic lvl, input int bits);
    rxd <= lvl;
    repeat (bits * div) @(posedge mclk);
  endtask

  // Long break, then the wake gap before any message
  task automatic wake(input int bits, input int gap);
    @(posedge mclk);
    hold(BREAK_LVL, bits);
    hold(IDLE_LVL, 0);
    repeat (gap) @(posedge mclk);
  endtask

  // One 8N1 character, LSB first
  task automatic send(input logic [7:0] b);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) begin
      hold(b[i], 1);
    end
    hold(1'b1, 1);
  endtask
endmodule

// file: bench/test_serial_break_wakeup_attach.sv
// Self-checking bench for the break wake-up serial slave.
// Assumes serial_master drives rxd; bit time of 4 clocks.
`timescale 1ns/10ps
module test_serial_break_wakeup_attach;
  import wake_pkg::*;
  localparam logic [15:0] DIV = 16'h0004;
  // Wake gap, scaled far below real time
  localparam int GAP = 40;
  localparam int P_OK = 0, P_BAD = 1, P_DET = 2, P_TX = 3;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, cts = 1'b0, bfree = 1'b0;
  logic msg_ok = 1'b0, msg_bad = 1'b0, detach = 1'b0, tx_start = 1'b0;
  logic [7:0] tx_data = 8'h00, rx_data;
  logic rxd, txd_q, busy, brk, awake, att, cable, rxv, ferr;
  logic [7:0] rx_exp[$], tx_exp[$];
  int error_cnt = 0, n_tests = 0, n_brk = 0, n_ferr = 0, cyc = 0;

  always #2.5 mclk = ~mclk;

  serial_master u_master (.mclk(mclk), .rxd(rxd), .div(DIV));

  break_wake u_dut (
    .mclk(mclk), .rst(rst), .ce(ce), .rxd(rxd), .cts(cts),
    .txd_q(txd_q), .break_free(bfree), .baud_div(DIV),
    .rx_data_q(rx_data), .rx_valid_q(rxv), .frame_err_q(ferr),
    .msg_ok(msg_ok), .msg_bad(msg_bad), .detach(detach),
    .tx_start(tx_start), .tx_data(tx_data), .tx_busy_q(busy),
    .break_det_q(brk), .awake_q(awake), .attached_q(att),
    .cable_q(cable)
  );

  // ****************************************************************
  // Checking and reporting
  // ****************************************************************
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Received characters; an unexpected one always mismatches
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      error_cnt++;
      conclude();
    end
    if (brk === 1'b1) n_brk <= n_brk + 1;
    if (ferr === 1'b1) n_ferr <= n_ferr + 1;
    if (rxv === 1'b1) begin
      check(rx_data, rx_exp.size() ? rx_exp.pop_front() : ~rx_data);
    end
  end

  // Transmitted characters sampled mid-bit
  always begin
    logic [9:0] w;
    @(negedge txd_q);
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 10; i++) begin
      w[i] = txd_q;
      repeat (4) @(posedge mclk);
    end
    check({6'h00, w[9], w[0]}, 8'h02);
    check(w[8:1], tx_exp.size() ? tx_exp.pop_front() : ~w[8:1]);
  end

  // ****************************************************************
  // Stimulus
  // ****************************************************************
  task automatic strobe(input int sel, input logic v);
    case (sel)
      P_OK: msg_ok <= v;
      P_BAD: msg_bad <= v;
      P_DET: detach <= v;
      default: tx_start <= v;
    endcase
  endtask

  task automatic pulse(input int sel);
    strobe(sel, 1'b1);
    @(posedge mclk);
    strobe(sel, 1'b0);
    repeat (6) @(posedge mclk);
  endtask

  task automatic rx_burst(input int n);
    logic [7:0] b;
    repeat (n) begin
      b = 8'($urandom);
      rx_exp.push_back(b);
      u_master.send(b);
    end
    repeat (8) @(posedge mclk);
  endtask

  task automatic send_tx();
    tx_data <= 8'($urandom);
    tx_start <= 1'b1;
    @(posedge mclk);
    tx_start <= 1'b0;
    tx_exp.push_back(tx_data);
    cts <= ~cts;
    @(posedge mclk);
    check({7'h00, busy}, 8'h01);
    for (int i = 0; i < 60 && busy !== 1'b0; i++) @(posedge mclk);
    repeat (3) @(posedge mclk);
    check({7'h00, cable}, {7'h00, cts});
  endtask

  initial begin
    void'($urandom(32'h71976376));
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    u_master.send(8'h55);
    u_master.wake(29, GAP);
    check({7'h00, awake}, 8'h00);
    check(8'(n_brk), 8'h00);
    u_master.wake(32, GAP);
    check(8'(n_brk), 8'h01);
    check({7'h00, awake}, 8'h01);
    rx_burst(4);
    pulse(P_OK);
    check({7'h00, att}, 8'h01);
    repeat (3) send_tx();
    pulse(P_DET);
    check({7'h00, awake}, 8'h00);
    pulse(P_TX);
    u_master.send(8'ha3);
    u_master.wake(31, GAP);
    check(8'(n_brk), 8'h02);
    rx_burst(1);
    pulse(P_BAD);
    check({7'h00, awake}, 8'h00);
    bfree <= 1'b1;
    repeat (8) @(posedge mclk);
    check({7'h00, awake}, 8'h01);
    // Break while awake: one framing error, no data
    u_master.wake(30, GAP);
    check(8'(n_brk), 8'h03);
    check(8'(n_ferr), 8'h01);
    rx_burst(3);
    // Low clock enable holds the cable flag
    ce <= 1'b0;
    cts <= ~cts;
    repeat (8) @(posedge mclk);
    check({7'h00, cable}, {7'h00, ~cts});
    ce <= 1'b1;
    repeat (5) @(posedge mclk);
    check({7'h00, cable}, {7'h00, cts});
    check(8'(rx_exp.size() + tx_exp.size()), 8'h00);
    conclude();
  end
endmodule
